/* File: tg_signal_window_gen.sv */
`timescale 1ns/100ps
module tg_signal_window_gen
  import tg_window_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic subframe_start,
  input wire logic frame_start,
  input wire logic reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  output logic [23:0] reg_rdata,
  output logic calc_signal,
  output logic power_down_signal,
  output logic interrupt_signal,
  output logic capture_signal,
  output logic [15:0] clock_position,
  output logic [11:0] subframe_position
);
  typedef struct packed {
    logic [15:0] calc_window_begin;
    logic [15:0] calc_window_finish;
    logic [15:0] power_down_window_begin;
    logic [15:0] power_down_window_finish;
    logic [11:0] interrupt_mask_first_subframe;
    logic [11:0] interrupt_mask_last_subframe;
    logic [11:0] capture_mask_first_subframe;
    logic [11:0] capture_mask_last_subframe;
    logic [15:0] clocks;
    logic [11:0] subframes;
    logic [23:0] rdata;
    logic irq_level;
    logic cap_level;
  } gen_state_type;

  gen_state_type cur;
  gen_state_type next_cur;

  tg_window_if calc_bus();
  tg_window_if pdn_bus();
  tg_window_if irq_bus();
  tg_window_if cap_bus();

  // Interrupt and capture are whole-sub-frame levels gated by their masks
  logic irq_in_mask;
  logic cap_in_mask;
  assign irq_in_mask = cur.subframes >= cur.interrupt_mask_first_subframe &&
    cur.subframes <= cur.interrupt_mask_last_subframe;
  assign cap_in_mask = cur.subframes >= cur.capture_mask_first_subframe &&
    cur.subframes <= cur.capture_mask_last_subframe;

  always_comb begin
    next_cur = cur;
    // Counters: clocks within sub-frame, sub-frames within frame
    if (subframe_start || frame_start) begin
      next_cur.clocks = '0;
    end else if (cur.clocks != 16'hFFFF) begin
      next_cur.clocks = cur.clocks + 16'h0001;
    end
    if (frame_start) begin
      next_cur.subframes = '0;
    end else if (subframe_start) begin
      next_cur.subframes = cur.subframes + 12'h001;
    end
    if (reg_write) begin
      case (reg_addr)
        calc_signal_start_addr: next_cur.calc_window_begin = reg_wdata[position_msb:0];
        calc_signal_end_addr: next_cur.calc_window_finish = reg_wdata[position_msb:0];
        power_down_signal_start_addr: begin
          next_cur.power_down_window_begin = reg_wdata[position_msb:0];
        end
        power_down_signal_end_addr: begin
          next_cur.power_down_window_finish = reg_wdata[position_msb:0];
        end
        interrupt_subframe_mask_addr: begin
          next_cur.interrupt_mask_last_subframe = reg_wdata[mask_last_lsb +: sub_width];
          next_cur.interrupt_mask_first_subframe = reg_wdata[mask_first_lsb +: sub_width];
        end
        capture_subframe_mask_addr: begin
          next_cur.capture_mask_last_subframe = reg_wdata[mask_last_lsb +: sub_width];
          next_cur.capture_mask_first_subframe = reg_wdata[mask_first_lsb +: sub_width];
        end
        default: ;
      endcase
    end
    // Reserved upper byte of the position registers is not stored and reads zero
    case (reg_addr)
      calc_signal_start_addr: next_cur.rdata = {8'h00, cur.calc_window_begin};
      calc_signal_end_addr: next_cur.rdata = {8'h00, cur.calc_window_finish};
      power_down_signal_start_addr: next_cur.rdata = {8'h00, cur.power_down_window_begin};
      power_down_signal_end_addr: next_cur.rdata = {8'h00, cur.power_down_window_finish};
      interrupt_subframe_mask_addr: begin
        next_cur.rdata = {cur.interrupt_mask_last_subframe, cur.interrupt_mask_first_subframe};
      end
      capture_subframe_mask_addr: begin
        next_cur.rdata = {cur.capture_mask_last_subframe, cur.capture_mask_first_subframe};
      end
      default: next_cur.rdata = 24'h000000;
    endcase
    next_cur.irq_level = irq_bus.window_out;
    next_cur.cap_level = cap_bus.window_out;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cur <= '{calc_window_begin: calc_signal_start_reset,
               calc_window_finish: calc_signal_end_reset,
               power_down_window_begin: power_down_signal_start_reset,
               power_down_window_finish: power_down_signal_end_reset,
               interrupt_mask_first_subframe: mask_field_reset,
               interrupt_mask_last_subframe: mask_field_reset,
               capture_mask_first_subframe: mask_field_reset,
               capture_mask_last_subframe: mask_field_reset,
               clocks: 16'h0000,
               subframes: 12'h000,
               rdata: 24'h000000,
               irq_level: 1'b0,
               cap_level: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  // Calculation and power-down are placed inside the sub-frame, no mask here
  assign calc_bus.clock_count = cur.clocks;
  assign calc_bus.subframe_count = cur.subframes;
  assign calc_bus.begin_pos = cur.calc_window_begin;
  assign calc_bus.finish_pos = cur.calc_window_finish;
  assign calc_bus.first_subframe = 12'h000;
  assign calc_bus.last_subframe = 12'hFFF;
  assign calc_bus.use_mask = 1'b0;

  assign pdn_bus.clock_count = cur.clocks;
  assign pdn_bus.subframe_count = cur.subframes;
  assign pdn_bus.begin_pos = cur.power_down_window_begin;
  assign pdn_bus.finish_pos = cur.power_down_window_finish;
  assign pdn_bus.first_subframe = 12'h000;
  assign pdn_bus.last_subframe = 12'hFFF;
  assign pdn_bus.use_mask = 1'b0;

  // Masked signals span the whole sub-frame; the mask alone places them
  assign irq_bus.clock_count = cur.clocks;
  assign irq_bus.subframe_count = cur.subframes;
  assign irq_bus.begin_pos = 16'h0000;
  assign irq_bus.finish_pos = 16'hFFFF;
  assign irq_bus.first_subframe = cur.interrupt_mask_first_subframe;
  assign irq_bus.last_subframe = cur.interrupt_mask_last_subframe;
  assign irq_bus.use_mask = 1'b1;

  assign cap_bus.clock_count = cur.clocks;
  assign cap_bus.subframe_count = cur.subframes;
  assign cap_bus.begin_pos = 16'h0000;
  assign cap_bus.finish_pos = 16'hFFFF;
  assign cap_bus.first_subframe = cur.capture_mask_first_subframe;
  assign cap_bus.last_subframe = cur.capture_mask_last_subframe;
  assign cap_bus.use_mask = 1'b1;

  tg_window_unit calc_unit (.ref_clk(ref_clk), .srst(srst), .port(calc_bus.win));
  tg_window_unit pdn_unit (.ref_clk(ref_clk), .srst(srst), .port(pdn_bus.win));
  tg_window_unit irq_unit (.ref_clk(ref_clk), .srst(srst), .port(irq_bus.win));
  tg_window_unit cap_unit (.ref_clk(ref_clk), .srst(srst), .port(cap_bus.win));

  assign calc_signal = calc_bus.window_out;
  assign power_down_signal = pdn_bus.window_out;
  assign interrupt_signal = cur.irq_level & irq_in_mask;
  assign capture_signal = cur.cap_level & cap_in_mask;
  assign reg_rdata = cur.rdata;
  assign clock_position = cur.clocks;
  assign subframe_position = cur.subframes;

  clock_restart_a: assert property (@(posedge ref_clk) disable iff (srst)
    (subframe_start || frame_start) |=> clock_position == 16'h0000)
    else $error("clock count did not restart");
  subframe_restart_a: assert property (@(posedge ref_clk) disable iff (srst)
    frame_start |=> subframe_position == 12'h000)
    else $error("sub-frame count did not restart");
  calc_open_a: assert property (@(posedge ref_clk) disable iff (srst)
    (!calc_signal && clock_position == cur.calc_window_begin && clock_position != 16'h0000
     && cur.calc_window_begin != cur.calc_window_finish && !subframe_start && !frame_start
     && !reg_write) |=> calc_signal)
    else $error("calculation signal did not start");
  calc_close_a: assert property (@(posedge ref_clk) disable iff (srst)
    (calc_signal && clock_position == cur.calc_window_finish && cur.calc_window_finish != 16'h0000
     && !reg_write) |=> !calc_signal)
    else $error("calculation signal did not end");
  pdn_open_a: assert property (@(posedge ref_clk) disable iff (srst)
    (!power_down_signal && clock_position == cur.power_down_window_begin
     && clock_position != 16'h0000 && !reg_write
     && cur.power_down_window_begin != cur.power_down_window_finish) |=> power_down_signal)
    else $error("power-down signal did not start");
  pdn_close_a: assert property (@(posedge ref_clk) disable iff (srst)
    (power_down_signal && clock_position == cur.power_down_window_finish
     && cur.power_down_window_finish != 16'h0000 && !reg_write) |=> !power_down_signal)
    else $error("power-down signal did not end");
  // The unit's level lags the mask by two edges, so the mask must have held then too
  irq_mask_a: assert property (@(posedge ref_clk) disable iff (srst)
    interrupt_signal |-> $past(irq_in_mask, 2)) else $error("interrupt outside mask");
  cap_mask_a: assert property (@(posedge ref_clk) disable iff (srst)
    capture_signal |-> $past(cap_in_mask, 2)) else $error("capture outside mask");
  mask_write_a: assert property (@(posedge ref_clk) disable iff (srst)
    (reg_write && reg_addr == interrupt_subframe_mask_addr) |=>
    cur.interrupt_mask_last_subframe == $past(reg_wdata[23:12]) &&
    cur.interrupt_mask_first_subframe == $past(reg_wdata[11:0]))
    else $error("interrupt mask fields not stored");
  reserved_read_a: assert property (@(posedge ref_clk) disable iff (srst)
    ($past(reg_addr) == calc_signal_start_addr) |-> reg_rdata[23:16] == 8'h00)
    else $error("reserved byte not zero");
  capture_write_a: assert property (@(posedge ref_clk) disable iff (srst)
    (reg_write && reg_addr == capture_subframe_mask_addr) |=>
    cur.capture_mask_last_subframe == $past(reg_wdata[23:12]))
    else $error("capture mask end not stored");

  calc_seen_c: cover property (@(posedge ref_clk) disable iff (srst) $rose(calc_signal));
  pdn_seen_c: cover property (@(posedge ref_clk) disable iff (srst) $fell(power_down_signal));
  irq_seen_c: cover property (@(posedge ref_clk) disable iff (srst) $rose(interrupt_signal));
  cap_seen_c: cover property (@(posedge ref_clk) disable iff (srst) $rose(capture_signal));
endmodule

/* File: tg_signal_window_gen_bench.sv */
`timescale 1ns/100ps
module tg_signal_window_gen_bench
  import tg_window_pkg::*;
;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic subframe_start = 1'b0;
  logic frame_start = 1'b0;
  logic reg_write = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [23:0] reg_wdata = 24'h000000;
  logic [23:0] reg_rdata;
  logic calc_signal;
  logic power_down_signal;
  logic interrupt_signal;
  logic capture_signal;
  logic [15:0] clock_position;
  logic [11:0] subframe_position;
  int fail_count = 0;
  int samples_checked = 0;

  tg_signal_window_gen dut (
    .ref_clk(ref_clk),
    .srst(srst),
    .subframe_start(subframe_start),
    .frame_start(frame_start),
    .reg_write(reg_write),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .calc_signal(calc_signal),
    .power_down_signal(power_down_signal),
    .interrupt_signal(interrupt_signal),
    .capture_signal(capture_signal),
    .clock_position(clock_position),
    .subframe_position(subframe_position)
  );

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // Inputs move a fixed 1 ns after the rising edge, clear of the sampling edge
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic write_reg(input logic [7:0] addr, input logic [23:0] data);
    reg_write = 1'b1;
    reg_addr = addr;
    reg_wdata = data;
    tick();
    reg_write = 1'b0;
  endtask

  task automatic read_check(input logic [7:0] addr, input logic [23:0] exp);
    reg_addr = addr;
    tick();
    check(reg_rdata, exp, "register read");
  endtask

  task automatic pulse_subframe(input logic whole_frame);
    subframe_start = ~whole_frame;
    frame_start = whole_frame;
    tick();
    subframe_start = 1'b0;
    frame_start = 1'b0;
  endtask

  task automatic reset_values();
    read_check(calc_signal_start_addr, {8'h00, calc_signal_start_reset});
    read_check(calc_signal_end_addr, {8'h00, calc_signal_end_reset});
    read_check(power_down_signal_start_addr, {8'h00, power_down_signal_start_reset});
    read_check(power_down_signal_end_addr, {8'h00, power_down_signal_end_reset});
    read_check(interrupt_subframe_mask_addr, {mask_field_reset, mask_field_reset});
    read_check(capture_subframe_mask_addr, {mask_field_reset, mask_field_reset});
    read_check(8'h95, 24'h000000);
  endtask

  task automatic write_readback();
    // Back-to-back writes; reserved byte of a position register never sticks
    write_reg(calc_signal_start_addr, 24'hAB1234);
    write_reg(calc_signal_end_addr, 24'hFF5678);
    write_reg(8'h95, 24'h123456);
    write_reg(interrupt_subframe_mask_addr, 24'hABC123);
    read_check(calc_signal_start_addr, 24'h001234);
    read_check(calc_signal_end_addr, 24'h005678);
    read_check(8'h95, 24'h000000);
    read_check(interrupt_subframe_mask_addr, 24'hABC123);
    write_reg(capture_subframe_mask_addr, 24'h987654);
    read_check(capture_subframe_mask_addr, 24'h987654);
  endtask

  task automatic windows();
    logic [15:0] p;
    write_reg(calc_signal_start_addr, 24'h00000A);
    write_reg(calc_signal_end_addr, 24'h000014);
    write_reg(power_down_signal_start_addr, 24'h000005);
    write_reg(power_down_signal_end_addr, 24'h000008);
    pulse_subframe(1'b0);
    check({8'h00, clock_position}, 24'h000000, "clock restart");
    for (int i = 0; i < 30; i++) begin
      p = clock_position;
      tick();
      check({8'h00, clock_position}, {8'h00, p + 16'h0001}, "clock count");
      check({23'h000000, calc_signal}, {23'h000000, p >= 16'h000A && p < 16'h0014},
            "calc window");
      check({23'h000000, power_down_signal}, {23'h000000, p >= 16'h0005 && p < 16'h0008},
            "power-down window");
    end
  endtask

  task automatic masks();
    // Interrupt in sub-frames 2..3, capture only in 1; checked at clock 4, the last cycle of each sub-frame
    write_reg(interrupt_subframe_mask_addr, 24'h003002);
    write_reg(capture_subframe_mask_addr, 24'h001001);
    for (int n = 0; n < 5; n++) begin
      pulse_subframe(n == 0);
      repeat (4) tick();
      check({12'h000, subframe_position}, 24'(n), "sub-frame count");
      check({23'h000000, interrupt_signal}, {23'h000000, n >= 2 && n <= 3},
            "interrupt mask");
      check({23'h000000, capture_signal}, {23'h000000, n == 1}, "capture mask");
    end
  endtask

  task automatic results();
    $display("fail_count=%0d samples_checked=%0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    reset_values();
    write_readback();
    windows();
    masks();
    results();
  end

  // Whole run is under a hundred cycles; this leaves wide margin
  initial begin
    #50000;
    fail_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    results();
  end
endmodule

/* File: tg_window_if.sv */
`timescale 1ns/100ps
interface tg_window_if;
  logic [15:0] clock_count;
  logic [11:0] subframe_count;
  logic [15:0] begin_pos;
  logic [15:0] finish_pos;
  logic [11:0] first_subframe;
  logic [11:0] last_subframe;
  logic use_mask;
  logic window_out;
  modport ctrl(
    output begin_pos, finish_pos, first_subframe, last_subframe, use_mask,
    output clock_count, subframe_count,
    input window_out
  );
  modport win(
    input begin_pos, finish_pos, first_subframe, last_subframe, use_mask,
    input clock_count, subframe_count,
    output window_out
  );
endinterface

/* File: tg_window_pkg.sv */
package tg_window_pkg;
  localparam int unsigned reg_addr_width = 8;
  localparam int unsigned reg_data_width = 24;
  localparam int unsigned pos_width = 16;
  localparam int unsigned sub_width = 12;
  localparam logic [7:0] calc_signal_start_addr = 8'h91;
  localparam logic [7:0] calc_signal_end_addr = 8'h92;
  localparam logic [7:0] power_down_signal_start_addr = 8'h93;
  localparam logic [7:0] power_down_signal_end_addr = 8'h94;
  localparam logic [7:0] interrupt_subframe_mask_addr = 8'h97;
  localparam logic [7:0] capture_subframe_mask_addr = 8'h98;
  localparam logic [15:0] calc_signal_start_reset = 16'h2134;
  localparam logic [15:0] calc_signal_end_reset = 16'h2EE0;
  localparam logic [15:0] power_down_signal_start_reset = 16'h0000;
  localparam logic [15:0] power_down_signal_end_reset = 16'hFFFF;
  localparam logic [11:0] mask_field_reset = 12'h000;
  localparam int unsigned mask_first_lsb = 0;
  localparam int unsigned mask_last_lsb = 12;
  localparam int unsigned position_msb = 15;
  typedef enum logic [1:0] {
    win_idle = 2'b01,
    win_active = 2'b10
  } win_state_type;
endpackage

/* File: tg_window_unit.sv */
`timescale 1ns/100ps
module tg_window_unit
  import tg_window_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  tg_window_if.win port
);
  typedef struct packed {
    win_state_type state;
    logic out;
  } unit_state_type;
  unit_state_type cur;
  unit_state_type next_cur;
  logic in_frame;

  // Mask passes sub-frames from first to last inclusive
  assign in_frame = !port.use_mask ||
    (port.subframe_count >= port.first_subframe &&
     port.subframe_count <= port.last_subframe);

  always_comb begin
    next_cur = cur;
    case (cur.state)
      win_idle: begin
        if (port.clock_count == port.begin_pos && port.begin_pos != port.finish_pos) begin
          next_cur.state = win_active;
        end
      end
      win_active: begin
        if (port.clock_count == port.finish_pos || port.clock_count == '0) begin
          next_cur.state = win_idle;
        end
      end
      default: next_cur.state = win_idle;
    endcase
    // A new sub-frame restarting at the begin position reopens at once
    if (port.clock_count == '0 && port.begin_pos == '0 && port.finish_pos != '0) begin
      next_cur.state = win_active;
    end
    next_cur.out = (next_cur.state == win_active) && in_frame;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cur <= '{state: win_idle, out: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign port.window_out = cur.out;

  window_gate_a: assert property (@(posedge ref_clk) disable iff (srst)
    cur.out |-> $past(in_frame)) else $error("window out outside mask");
  window_open_a: assert property (@(posedge ref_clk) disable iff (srst)
    (cur.state == win_idle && port.clock_count == port.begin_pos && port.begin_pos != '0
     && port.begin_pos != port.finish_pos) |=> cur.state == win_active)
    else $error("window did not open at begin");
endmodule
